// ---- logic/ppl_lanes.sv ----
// Per-lane PHY interface logic for eight transceiver lanes.
`timescale 1ns/1ps
`default_nettype none
`include "ppl_defines.svh"
// Operation
// - Lanes zero to seven each have their own identical signal set.
// - Async receive idle passes a two-stage synchroniser before use.
// - A high invert output tells the transceiver to invert the rx pair.
// - Tx control flag bit 0 marks the low byte, bit 1 the high byte.
// - Negative disparity is forced only while compliance is sent.
// - A high idle force holds the transmitter idle in every power state.
// - Power state is driven as 00, 01 or 10 and never as reserved 11.
// - Transmit symbols leave as one 16-bit word per lane per clock.
// - The probe output starts detection in P1 or loopback in P0.
module ppl_lanes #(
   parameter int LANES = `PPL_NUM_LANES,
   parameter int DEPTH = `PPL_FIFO_DEPTH
) (
   input wire logic clk, // Interface clock, 10 MHz.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic [LANES-1:0] lane_rx_aligned, // Lane bonded.
   input wire logic [LANES-1:0][1:0] lane_rx_ctrl_flag, // Rx control.
   input wire logic [LANES-1:0][15:0] lane_rx_symbols, // Rx word.
   input wire logic [LANES-1:0] lane_rx_idle_detect, // Async rx idle.
   input wire logic [LANES-1:0] lane_phy_done_pulse, // Done pulse.
   input wire logic [LANES-1:0][2:0] lane_rx_status_code, // Rx status.
   input wire logic [LANES-1:0] lane_rx_locked, // Rx valid.
   output logic [LANES-1:0] lane_rx_invert, // Invert rx pair.
   output logic [LANES-1:0][1:0] lane_tx_ctrl_flag, // Tx control.
   output logic [LANES-1:0][15:0] lane_tx_symbols, // Tx word.
   output logic [LANES-1:0] lane_tx_neg_disparity, // Compliance.
   output logic [LANES-1:0] lane_tx_idle_force, // Tx idle.
   output logic [LANES-1:0][1:0] lane_power_state, // Power state.
   output logic far_receiver_probe, // Start detect or loopback.
   input wire ppl_pkg::ppl_word_t [LANES-1:0] user_tx_word, // Tx in.
   input wire ppl_pkg::ppl_lane_ctl_t [LANES-1:0] user_lane_ctl, // Ctl.
   input wire logic user_compliance, // Sending compliance pattern.
   input wire logic user_probe_req, // Probe or loopback request.
   output ppl_pkg::ppl_word_t [LANES-1:0] user_rx_word, // Rx out.
   output logic [LANES-1:0] user_rx_valid, // Rx out holds a word.
   input wire logic [LANES-1:0] user_rx_ready, // User takes rx word.
   output logic [LANES-1:0] user_rx_drop, // Word lost, FIFO full.
   output logic [LANES-1:0] user_rx_idle, // Synchronised rx idle.
   output logic [LANES-1:0] user_rx_aligned, // Registered aligned.
   output logic [LANES-1:0] user_far_found, // Far receiver seen.
   output logic [LANES-1:0] user_phy_done, // Done pulse copy.
   output ppl_pkg::ppl_rx_evt_t [LANES-1:0] user_rx_evt // Status pulses.
);
   import ppl_pkg::*;

   // Refuses lane counts that the port widths cannot serve.
   if (LANES < 1 || LANES > `PPL_NUM_LANES) begin : g_bad_lanes
      $error("ppl_lanes supports one to eight lanes");
   end

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [LANES-1:0] idle_s1;
      logic [LANES-1:0] idle_s2;
      logic [LANES-1:0] invert;
      ppl_word_t [LANES-1:0] tx_word;
      logic [LANES-1:0] neg_disp;
      logic [LANES-1:0] idle_force;
      logic [LANES-1:0][1:0] power;
      logic probe;
      logic [LANES-1:0] probe_pend;
      logic [LANES-1:0] far_found;
      logic [LANES-1:0] done;
      logic [LANES-1:0] aligned;
      logic [LANES-1:0] drop;
      ppl_rx_evt_t [LANES-1:0] evt;
   } ppl_st_t;
   ppl_st_t s_reg, s_next;

   logic [LANES-1:0] fifo_in_ready;
   logic [LANES-1:0] fifo_out_valid;
   ppl_word_t [LANES-1:0] fifo_out_data;
   logic [LANES-1:0] rx_push;

   // Maps a requested power state onto a legal code.
   function automatic logic [1:0] ppl_legal_power(input logic [1:0] req);
      ppl_legal_power = (req == `PPL_PWR_RSVD) ? `PPL_PWR_P1 : req;
   endfunction

   // ----------------------------------------------------------------
   // Receive path FIFOs
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         assign rx_push[g] = lane_rx_locked[g];
         ppl_fifo #(.WIDTH($bits(ppl_word_t)), .DEPTH(DEPTH)) u_fifo (
            .clk(clk),
            .reset_n(reset_n),
            .in_data({lane_rx_ctrl_flag[g], lane_rx_symbols[g]}),
            .in_valid(rx_push[g]),
            .in_ready(fifo_in_ready[g]),
            .out_data(fifo_out_data[g]),
            .out_valid(fifo_out_valid[g]),
            .out_ready(user_rx_ready[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.idle_s1 = lane_rx_idle_detect;
      s_next.idle_s2 = s_reg.idle_s1;
      s_next.probe = user_probe_req;
      s_next.aligned = lane_rx_aligned;
      s_next.done = lane_phy_done_pulse;
      for (int i = 0; i < LANES; i++) begin
         s_next.invert[i] = user_lane_ctl[i].invert;
         s_next.tx_word[i] = user_tx_word[i];
         s_next.neg_disp[i] = user_compliance &&
            user_lane_ctl[i].neg_disparity;
         s_next.idle_force[i] = user_lane_ctl[i].idle_force;
         s_next.power[i] =
            ppl_legal_power(user_lane_ctl[i].power_state);
         s_next.drop[i] = rx_push[i] && !fifo_in_ready[i];
         // A probe arms the lane; the next done pulse closes it.
         if (lane_phy_done_pulse[i] && s_reg.probe_pend[i]) begin
            s_next.probe_pend[i] = 1'b0;
            s_next.far_found[i] = (lane_rx_status_code[i] ==
               `PPL_ST_RX_DET);
         end
         // A new probe wins over a done pulse that closes the old one.
         if (user_probe_req && !s_reg.probe)
            s_next.probe_pend[i] = 1'b1;
         s_next.evt[i] = '0;
         if (lane_rx_locked[i]) begin
            unique case (lane_rx_status_code[i])
               `PPL_ST_SKP_ADD: s_next.evt[i].skip_added = 1'b1;
               `PPL_ST_SKP_REM: s_next.evt[i].skip_removed = 1'b1;
               `PPL_ST_DEC_ERR: s_next.evt[i].decode_err = 1'b1;
               `PPL_ST_EB_OVF: s_next.evt[i].eb_overflow = 1'b1;
               `PPL_ST_EB_UNF: s_next.evt[i].eb_underflow = 1'b1;
               `PPL_ST_DISP_ERR: s_next.evt[i].disp_err = 1'b1;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < LANES; i++) begin
         lane_tx_ctrl_flag[i] = s_reg.tx_word[i].ctrl_flag;
         lane_tx_symbols[i] = s_reg.tx_word[i].symbols;
         user_rx_evt[i] = s_reg.evt[i];
      end
   end
   assign lane_rx_invert = s_reg.invert;
   assign lane_tx_neg_disparity = s_reg.neg_disp;
   assign lane_tx_idle_force = s_reg.idle_force;
   assign lane_power_state = s_reg.power;
   assign far_receiver_probe = s_reg.probe;
   assign user_rx_word = fifo_out_data;
   assign user_rx_valid = fifo_out_valid;
   assign user_rx_drop = s_reg.drop;
   assign user_rx_idle = s_reg.idle_s2;
   assign user_rx_aligned = s_reg.aligned;
   assign user_far_found = s_reg.far_found;
   assign user_phy_done = s_reg.done;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   generate
      for (g = 0; g < LANES; g++) begin : g_chk
         chk_power_legal: assert property (
            @(posedge clk) disable iff (!reset_n)
            lane_power_state[g] != `PPL_PWR_RSVD)
            else $error("reserved power state driven");
         chk_power_follow: assert property (
            @(posedge clk) disable iff (!reset_n)
            user_lane_ctl[g].power_state != `PPL_PWR_RSVD |=>
            lane_power_state[g] == $past(user_lane_ctl[g].power_state))
            else $error("power state did not follow request");
         chk_compl_only: assert property (
            @(posedge clk) disable iff (!reset_n)
            lane_tx_neg_disparity[g] |-> $past(user_compliance))
            else $error("disparity forced outside compliance");
         chk_idle_sync: assert property (
            @(posedge clk) disable iff (!reset_n)
            ##2 user_rx_idle[g] == $past(lane_rx_idle_detect[g], 2))
            else $error("idle not delayed two cycles");
         chk_tx_word: assert property (
            @(posedge clk) disable iff (!reset_n)
            ##1 lane_tx_symbols[g] == $past(user_tx_word[g].symbols))
            else $error("tx word not passed on");
         chk_tx_flag: assert property (
            @(posedge clk) disable iff (!reset_n)
            ##1 lane_tx_ctrl_flag[g] == $past(user_tx_word[g].ctrl_flag))
            else $error("tx flags not passed on");
         chk_invert: assert property (
            @(posedge clk) disable iff (!reset_n)
            $rose(user_lane_ctl[g].invert) |=> lane_rx_invert[g])
            else $error("invert not driven");
         chk_idle_force: assert property (
            @(posedge clk) disable iff (!reset_n)
            user_lane_ctl[g].idle_force |=> lane_tx_idle_force[g])
            else $error("idle force not driven");
         chk_far_found: assert property (
            @(posedge clk) disable iff (!reset_n)
            s_reg.probe_pend[g] && lane_phy_done_pulse[g] &&
            lane_rx_status_code[g] == `PPL_ST_RX_DET |=> user_far_found[g])
            else $error("far receiver not recorded");
         chk_unlocked: assert property (
            @(posedge clk) disable iff (!reset_n)
            !lane_rx_locked[g] |=> user_rx_evt[g] == '0)
            else $error("status used while unlocked");
      end
   endgenerate
endmodule // ppl_lanes
`default_nettype wire

// ---- logic/ppl_defines.svh ----
// Constants for the per-lane PHY interface block.
`ifndef PPL_DEFINES_SVH
`define PPL_DEFINES_SVH
`define PPL_NUM_LANES 8
`define PPL_SYM_W 16
`define PPL_FIFO_DEPTH 8
`define PPL_ST_OK 3'h0
`define PPL_ST_SKP_ADD 3'h1
`define PPL_ST_SKP_REM 3'h2
`define PPL_ST_RX_DET 3'h3
`define PPL_ST_DEC_ERR 3'h4
`define PPL_ST_EB_OVF 3'h5
`define PPL_ST_EB_UNF 3'h6
`define PPL_ST_DISP_ERR 3'h7
`define PPL_PWR_P0 2'h0
`define PPL_PWR_P0S 2'h1
`define PPL_PWR_P1 2'h2
`define PPL_PWR_RSVD 2'h3
`endif

// ---- logic/ppl_pkg.sv ----
// Types shared by the per-lane PHY interface block.
`default_nettype none
package ppl_pkg;
   typedef struct packed {
      logic [1:0] ctrl_flag;
      logic [15:0] symbols;
   } ppl_word_t;
   typedef struct packed {
      logic neg_disparity;
      logic idle_force;
      logic invert;
      logic [1:0] power_state;
   } ppl_lane_ctl_t;
   typedef struct packed {
      logic decode_err;
      logic disp_err;
      logic eb_overflow;
      logic eb_underflow;
      logic skip_added;
      logic skip_removed;
   } ppl_rx_evt_t;
endpackage
`default_nettype wire

// ---- logic/ppl_fifo.sv ----
// Small flip-flop FIFO used in the receive symbol path.
`timescale 1ns/1ps
`default_nettype none
module ppl_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8
) (
   input wire logic clk, // Clock.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic [WIDTH-1:0] in_data, // Word to store.
   input wire logic in_valid, // Word offered.
   output logic in_ready, // Room for a word.
   output logic [WIDTH-1:0] out_data, // Oldest word.
   output logic out_valid, // A word is held.
   input wire logic out_ready // Drain side takes the word.
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   // Refuses depths that the wrapping pointers cannot serve.
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("ppl_fifo depth must be a power of two of at least two");
   end
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } ppl_fifo_st_t;
   ppl_fifo_st_t s_reg, s_next;
   logic push, pop;
   assign in_ready = (s_reg.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s_reg.cnt != '0);
   assign out_data = s_reg.mem[s_reg.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_comb begin
      s_next = s_reg;
      if (push) begin
         s_next.mem[s_reg.wp] = in_data;
         s_next.wp = s_reg.wp + 1'b1;
      end
      if (pop)
         s_next.rp = s_reg.rp + 1'b1;
      s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end
endmodule // ppl_fifo
`default_nettype wire

// ---- tb/ppl_xcvr_model.sv ----
// Transceiver lane model that feeds the receive side of the lane block.
`timescale 1ns/1ps
`default_nettype none
module ppl_xcvr_model #(
   parameter logic [7:0] FOUND_MASK = 8'h5a
) (
   input wire logic clk, // Interface clock.
   input wire logic far_receiver_probe, // Detect request.
   input wire logic [7:0] lane_tx_idle_force, // Hold line idle.
   output logic [7:0] lane_rx_aligned, // Lane bonded.
   output logic [7:0][1:0] lane_rx_ctrl_flag, // Rx control.
   output logic [7:0][15:0] lane_rx_symbols, // Rx word.
   output logic [7:0] lane_phy_done_pulse, // Done pulse.
   output logic [7:0][2:0] lane_rx_status_code, // Rx status.
   output logic [7:0] lane_rx_locked // Rx valid.
);
   logic [7:0] line_quiet;
   assign line_quiet = lane_tx_idle_force;
   initial begin
      {lane_rx_aligned, lane_rx_ctrl_flag, lane_rx_symbols} = '0;
      {lane_phy_done_pulse, lane_rx_status_code, lane_rx_locked} = '0;
   end
   // Unlocked lanes show the inverse of their last word, never a held copy.
   task automatic send(input logic [7:0] lk, input logic [7:0] al,
         input logic [7:0][17:0] w, input logic [7:0][2:0] st);
      @(posedge clk);
      lane_rx_aligned <= al;
      lane_rx_locked <= lk;
      lane_rx_status_code <= st;
      for (int l = 0; l < 8; l++) begin
         if (lk[l]) begin
            {lane_rx_ctrl_flag[l], lane_rx_symbols[l]} <=
               w[l];
         end else begin
            {lane_rx_ctrl_flag[l], lane_rx_symbols[l]} <=
               ~{lane_rx_ctrl_flag[l], lane_rx_symbols[l]};
         end
      end
   endtask
   // Answers a probe with a one-cycle done pulse and a status on every lane.
   always begin
      @(posedge far_receiver_probe);
      repeat (3) @(posedge clk);
      lane_rx_locked <= '0;
      for (int l = 0; l < 8; l++) begin
         lane_rx_status_code[l] <= FOUND_MASK[l] ? 3'h3 : 3'h0;
      end
      lane_phy_done_pulse <= '1;
      @(posedge clk);
      lane_phy_done_pulse <= '0;
      lane_rx_status_code <= '0;
   end
endmodule // ppl_xcvr_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the per-lane PHY interface block.
`timescale 1ns/1ps
`default_nettype none
`include "ppl_defines.svh"
module testbench;
   import ppl_pkg::*;
   localparam logic [7:0] FOUND = 8'h5a;
   logic clk, reset_n, user_compliance, user_probe_req, far_receiver_probe;
   logic [7:0] lane_rx_aligned, lane_rx_idle_detect, lane_phy_done_pulse;
   logic [7:0] lane_rx_locked, lane_rx_invert, lane_tx_neg_disparity;
   logic [7:0] lane_tx_idle_force, user_rx_valid, user_rx_ready, user_rx_drop;
   logic [7:0] user_rx_idle, user_rx_aligned, user_far_found, user_phy_done;
   logic [7:0] prev_lk, prev_al;
   logic [7:0][1:0] lane_rx_ctrl_flag, lane_tx_ctrl_flag, lane_power_state;
   logic [7:0][15:0] lane_rx_symbols, lane_tx_symbols;
   logic [7:0][2:0] lane_rx_status_code, prev_st;
   ppl_word_t [7:0] user_tx_word, user_rx_word;
   ppl_lane_ctl_t [7:0] user_lane_ctl;
   ppl_rx_evt_t [7:0] user_rx_evt;
   ppl_word_t exp_q[8][$];
   ppl_word_t exp_w;
   ppl_rx_evt_t exp_evt;
   int error_cnt = 0, num_checks = 0, cycles = 0, drop_total = 0;
   int seed = 32'h7194;
   ppl_lanes #(.LANES(8), .DEPTH(8)) uut (.clk, .reset_n, .lane_rx_aligned,
      .lane_rx_ctrl_flag, .lane_rx_symbols, .lane_rx_idle_detect,
      .lane_phy_done_pulse, .lane_rx_status_code, .lane_rx_locked,
      .lane_rx_invert, .lane_tx_ctrl_flag, .lane_tx_symbols,
      .lane_tx_neg_disparity, .lane_tx_idle_force, .lane_power_state,
      .far_receiver_probe, .user_tx_word, .user_lane_ctl, .user_compliance,
      .user_probe_req, .user_rx_word, .user_rx_valid, .user_rx_ready,
      .user_rx_drop, .user_rx_idle, .user_rx_aligned, .user_far_found,
      .user_phy_done, .user_rx_evt);
   ppl_xcvr_model #(.FOUND_MASK(FOUND)) xcvr (.clk, .far_receiver_probe,
      .lane_tx_idle_force, .lane_rx_aligned, .lane_rx_ctrl_flag,
      .lane_rx_symbols, .lane_phy_done_pulse, .lane_rx_status_code,
      .lane_rx_locked);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic check(input string what, input logic [17:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run;
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   function automatic ppl_rx_evt_t evt_of(input logic lk, input logic [2:0] s);
      ppl_rx_evt_t e;
      e = '0;
      if (lk === 1'b1) begin
         e = {s == `PPL_ST_DEC_ERR, s == `PPL_ST_DISP_ERR, s == `PPL_ST_EB_OVF,
            s == `PPL_ST_EB_UNF, s == `PPL_ST_SKP_ADD, s == `PPL_ST_SKP_REM};
      end
      return e;
   endfunction
   // ------------------------------------------------------------------
   // Receive side watcher
   // ------------------------------------------------------------------
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         error_cnt++;
         complete_run();
      end
      if (reset_n === 1'b1) begin
         drop_total += $countones(user_rx_drop);
         check("rx aligned", prev_al, user_rx_aligned);
         for (int l = 0; l < 8; l++) begin
            exp_evt = evt_of(prev_lk[l], prev_st[l]);
            check("rx event", exp_evt, user_rx_evt[l]);
            if ((user_rx_valid[l] & user_rx_ready[l]) === 1'b1) begin
               if (exp_q[l].size() == 0) begin
                  check("rx word extra", '0, '1);
               end else begin
                  exp_w = exp_q[l].pop_front();
                  check("rx word", exp_w, user_rx_word[l]);
               end
            end
         end
      end
      prev_al = lane_rx_aligned;
      prev_lk = lane_rx_locked;
      prev_st = lane_rx_status_code;
   end
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic tx_phase;
      ppl_word_t [7:0] pw;
      ppl_lane_ctl_t [7:0] pc;
      logic pcomp;
      logic [31:0] r;
      logic [1:0] ep;
      logic [17:0] got;
      for (int i = 0; i < 25; i++) begin
         @(posedge clk);
         pw = user_tx_word;
         pc = user_lane_ctl;
         pcomp = user_compliance;
         for (int l = 0; l < 8; l++) begin
            r = $random(seed);
            user_tx_word[l] <= r[17:0];
            user_lane_ctl[l] <= r[22:18];
         end
         user_compliance <= r[23];
         #1;
         for (int l = 0; l < 8; l++) begin
            ep = pc[l].power_state;
            if (ep == `PPL_PWR_RSVD) ep = `PPL_PWR_P1;
            r = 32'({pc[l].invert, pc[l].idle_force,
               pcomp & pc[l].neg_disparity, ep});
            got = {lane_tx_ctrl_flag[l], lane_tx_symbols[l]};
            check("tx word", pw[l], got);
            got = 18'({lane_rx_invert[l], lane_tx_idle_force[l],
               lane_tx_neg_disparity[l], lane_power_state[l]});
            check("tx control", r[4:0], got);
         end
      end
   endtask
   task automatic rx_send(input logic [7:0] lk);
      logic [7:0][17:0] w;
      logic [7:0][2:0] st;
      logic [31:0] r;
      for (int l = 0; l < 8; l++) begin
         r = $random(seed);
         w[l] = r[17:0];
         st[l] = r[20:18];
         if (lk[l] && exp_q[l].size() < 8) exp_q[l].push_back(w[l]);
      end
      xcvr.send(lk, r[31:24], w, st);
   endtask
   initial begin
      reset_n = 1'b0;
      {user_compliance, user_probe_req, user_rx_ready} = '0;
      {user_tx_word, user_lane_ctl, lane_rx_idle_detect} = '0;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      #1;
      check("reset power", '0, lane_power_state);
      check("reset probe", '0, far_receiver_probe);
      tx_phase();
      #37 lane_rx_idle_detect = 8'ha5;
      @(posedge clk);
      #1 check("idle early", 8'h00, user_rx_idle);
      @(posedge clk);
      #1 check("idle synced", 8'ha5, user_rx_idle);
      user_probe_req = 1'b1;
      @(posedge clk);
      #1 check("probe", 1'b1, far_receiver_probe);
      for (int n = 0; n < 20 && user_phy_done !== 8'hff; n++) @(posedge clk) #1;
      check("phy done", 8'hff, user_phy_done);
      @(posedge clk);
      #1 check("far found", FOUND, user_far_found);
      check("phy done end", 8'h00, user_phy_done);
      user_probe_req = 1'b0;
      user_rx_ready = 8'hff;
      repeat (30) rx_send(8'($random(seed)));
      repeat (2) rx_send(8'h00);
      @(posedge clk);
      user_rx_ready <= 8'h00;
      repeat (10) rx_send(8'hff);
      rx_send(8'h00);
      repeat (60) @(posedge clk) user_rx_ready <= 8'($random(seed));
      repeat (4) @(posedge clk) user_rx_ready <= 8'hff;
      #1 check("drops", 18'd16, 18'(drop_total));
      check("rx drained", 8'h00, user_rx_valid);
      complete_run();
   end
endmodule // testbench
`default_nettype wire
